// ---- rtl/cc_capcom.sv ----
// capture/compare unit top: apb registers, two time bases, sixteen channels
`include "cc_map.svh"

// Summary of operation
// - sixteen channels, one-cycle resolution, eight cycles when staggered
// - two independent 16-bit counters, each with its own reload register
// - each counter clocked from prescaled system clock or gp timer overflow
// - external count input can advance a time base
// - each channel picks a time base and capture or compare function
// - each channel owns one pin: capture input or compare output
// - capture edge stores the assigned time base count in the channel
// - each capture raises that channel's interrupt request
// - capture trigger: rising, falling or either edge, per channel
// - compare channels match on each time base step and act on equality
// - mode 0: interrupt on every match, pin untouched
// - mode 1: every match toggles the pin
// - mode 2: only first match per period interrupts, pin untouched
// - mode 3: pin high on match, low on overflow, once per period
// - double-register mode: two registers toggle one shared pin
// - single-event option stops a compare channel after one action
// - gp timer overflow is a clock source for both time bases
module cc_capcom
   import cc_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // channel pins
   input  wire logic [15:0] CC_PIN_I,
   output logic [15:0]      CC_PIN_O,
   output logic [15:0]      CC_PIN_OE_O,
   // count sources
   input  wire logic        EXT_COUNT_I,
   input  wire logic        GPT_OVF_I,
   // interrupt
   output logic             IRQ_O
);
   localparam int NCH = `CC_NUM_CH;

   logic        stagger_ff;
   cc_tbcfg_t   tba_cfg_ff;
   cc_tbcfg_t   tbb_cfg_ff;
   cc_chcfg_t   ch_cfg_ff [NCH];
   logic [15:0] ch_val_ff [NCH];
   logic [15:0] cap_cnt   [NCH];
   logic [15:0] spent_ff;
   logic [15:0] done_ff;
   logic [15:0] pin_ff;
   logic [15:0] oe_ff;
   logic [17:0] stat_ff;
   logic [17:0] mask_ff;
   logic [31:0] rdata_ff;
   logic        slverr_ff;
   logic [31:0] rd_word;
   logic        apb_setup;
   logic        apb_wr;
   logic [15:0] cfg_we;
   logic [15:0] val_we;
   logic [17:0] w1c;
   cc_tbout_t   tba;
   cc_tbout_t   tbb;
   cc_edges_t   edges;
   logic [15:0] match_v;
   logic [15:0] ovf_v;
   logic [15:0] cap_v;
   logic [15:0] act_v;
   logic [15:0] tog_v;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic [15:0] once_v;
   logic [15:0] single_v;
   logic [15:0] nxt_pin;
   logic [15:0] nxt_oe;
   logic [17:0] ev_v;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic in_region(input logic [11:0] a, input logic [11:0] base);
      return a[11:`CC_REGION_LSB] == base[11:`CC_REGION_LSB];
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, `CC_CTRL_OFS) | hit(a, `CC_TBA_CTRL_OFS) | hit(a, `CC_TBA_CNT_OFS) |
             hit(a, `CC_TBA_RLD_OFS) | hit(a, `CC_TBB_CTRL_OFS) | hit(a, `CC_TBB_CNT_OFS) |
             hit(a, `CC_TBB_RLD_OFS) | hit(a, `CC_IRQ_STAT_OFS) | hit(a, `CC_IRQ_MASK_OFS) |
             in_region(a, `CC_CH_CFG_OFS) | in_region(a, `CC_CH_VAL_OFS);
   endfunction

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign apb_setup = PSEL_I & ~PENABLE_I;
   assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & ~slverr_ff;
   assign PREADY_O  = PSEL_I & PENABLE_I;
   assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_ff;
   assign PRDATA_O  = rdata_ff;

   always_comb begin
      rd_word = '0;
      if (hit(PADDR_I, `CC_CTRL_OFS)) begin
         rd_word = 32'(stagger_ff);
      end else if (hit(PADDR_I, `CC_TBA_CTRL_OFS)) begin
         rd_word = 32'(tba_cfg_ff);
      end else if (hit(PADDR_I, `CC_TBA_CNT_OFS)) begin
         rd_word = 32'(tba.count);
      end else if (hit(PADDR_I, `CC_TBA_RLD_OFS)) begin
         rd_word = 32'(tba.reload);
      end else if (hit(PADDR_I, `CC_TBB_CTRL_OFS)) begin
         rd_word = 32'(tbb_cfg_ff);
      end else if (hit(PADDR_I, `CC_TBB_CNT_OFS)) begin
         rd_word = 32'(tbb.count);
      end else if (hit(PADDR_I, `CC_TBB_RLD_OFS)) begin
         rd_word = 32'(tbb.reload);
      end else if (hit(PADDR_I, `CC_IRQ_STAT_OFS)) begin
         rd_word = 32'(stat_ff);
      end else if (hit(PADDR_I, `CC_IRQ_MASK_OFS)) begin
         rd_word = 32'(mask_ff);
      end else if (in_region(PADDR_I, `CC_CH_CFG_OFS)) begin
         rd_word = 32'(ch_cfg_ff[PADDR_I[5:2]]);
      end else if (in_region(PADDR_I, `CC_CH_VAL_OFS)) begin
         rd_word = 32'(ch_val_ff[PADDR_I[5:2]]);
      end
   end

   // read data and error are sampled in the setup cycle
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         rdata_ff  <= '0;
         slverr_ff <= 1'b0;
      end else if (apb_setup) begin
         rdata_ff  <= rd_word;
         slverr_ff <= ~mapped(PADDR_I);
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         cfg_we[i] = apb_wr & in_region(PADDR_I, `CC_CH_CFG_OFS) & (PADDR_I[5:2] == 4'(i));
         val_we[i] = apb_wr & in_region(PADDR_I, `CC_CH_VAL_OFS) & (PADDR_I[5:2] == 4'(i));
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         stagger_ff <= 1'b0;
      end else if (apb_wr && hit(PADDR_I, `CC_CTRL_OFS)) begin
         stagger_ff <= PWDATA_I[`CC_STAGGER_BIT];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         tba_cfg_ff <= '0;
         tbb_cfg_ff <= '0;
      end else if (apb_wr) begin
         if (hit(PADDR_I, `CC_TBA_CTRL_OFS)) begin
            tba_cfg_ff <= cc_tbcfg_t'(PWDATA_I[`CC_TB_CFG_MSB:0]);
         end
         if (hit(PADDR_I, `CC_TBB_CTRL_OFS)) begin
            tbb_cfg_ff <= cc_tbcfg_t'(PWDATA_I[`CC_TB_CFG_MSB:0]);
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < NCH; i++) begin
            ch_cfg_ff[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cfg_we[i]) begin
               ch_cfg_ff[i] <= cc_chcfg_t'(PWDATA_I[`CC_CH_CFG_MSB:0]);
            end
         end
      end
   end

   // capture latches the count, winning over a write
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < NCH; i++) begin
            ch_val_ff[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap_v[i]) begin
               ch_val_ff[i] <= cap_cnt[i];
            end else if (val_we[i]) begin
               ch_val_ff[i] <= PWDATA_I[15:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // time bases and pin edges
   // ------------------------------------------------------------
   // two time bases with reload
   cc_timebase u_time_base_a (
      .clk_i      (CLK_I),
      .srst_i     (SRST_I),
      .cfg_i      (tba_cfg_ff),
      .stagger_i  (stagger_ff),
      .gpt_ovf_i  (GPT_OVF_I),
      .ext_tick_i (edges.rise[16]),
      .cnt_we_i   (apb_wr & hit(PADDR_I, `CC_TBA_CNT_OFS)),
      .rld_we_i   (apb_wr & hit(PADDR_I, `CC_TBA_RLD_OFS)),
      .wdata_i    (PWDATA_I[15:0]),
      .tb_o       (tba)
   );

   cc_timebase u_time_base_b (
      .clk_i      (CLK_I),
      .srst_i     (SRST_I),
      .cfg_i      (tbb_cfg_ff),
      .stagger_i  (stagger_ff),
      .gpt_ovf_i  (GPT_OVF_I),
      .ext_tick_i (edges.rise[16]),
      .cnt_we_i   (apb_wr & hit(PADDR_I, `CC_TBB_CNT_OFS)),
      .rld_we_i   (apb_wr & hit(PADDR_I, `CC_TBB_RLD_OFS)),
      .wdata_i    (PWDATA_I[15:0]),
      .tb_o       (tbb)
   );

   cc_pin_sync u_pin_sync (
      .clk_i   (CLK_I),
      .srst_i  (SRST_I),
      .pins_i  ({EXT_COUNT_I, CC_PIN_I}),
      .edges_o (edges)
   );

   // ------------------------------------------------------------
   // channel logic
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         // match on every time base step
         match_v[i] = ch_cfg_ff[i].tb_sel ? (tbb.step && (tbb.count == ch_val_ff[i]))
                                          : (tba.step && (tba.count == ch_val_ff[i]));
         ovf_v[i]   = ch_cfg_ff[i].tb_sel ? tbb.ovf : tba.ovf;
         cap_cnt[i] = ch_cfg_ff[i].tb_sel ? tbb.count : tba.count;
         single_v[i] = ch_cfg_ff[i].single;
      end
   end

   always_comb begin
      cap_v  = '0;
      act_v  = '0;
      tog_v  = '0;
      set_v  = '0;
      clr_v  = '0;
      once_v = '0;
      nxt_oe = '0;
      for (int i = 0; i < NCH; i++) begin
         case (ch_cfg_ff[i].mode)
            CC_CAP: begin
               cap_v[i] = (ch_cfg_ff[i].edge_sel[0] & edges.rise[i]) |
                          (ch_cfg_ff[i].edge_sel[1] & edges.fall[i]);
            end
            CC_CMP0: begin
               act_v[i] = match_v[i] & ~spent_ff[i];
            end
            CC_CMP1: begin
               act_v[i]  = match_v[i] & ~spent_ff[i];
               tog_v[i]  = act_v[i];
               nxt_oe[i] = 1'b1;
            end
            CC_CMP2: begin
               act_v[i]  = match_v[i] & ~spent_ff[i] & ~done_ff[i];
               once_v[i] = 1'b1;
            end
            // set on match, clear on overflow
            CC_CMP3: begin
               act_v[i]  = match_v[i] & ~spent_ff[i] & ~done_ff[i];
               set_v[i]  = act_v[i];
               clr_v[i]  = ovf_v[i];
               once_v[i] = 1'b1;
               nxt_oe[i] = 1'b1;
            end
            CC_DBL: begin
               act_v[i]  = (i < `CC_DBL_OFS) & (match_v[i] | match_v[4'(i + `CC_DBL_OFS)]) & ~spent_ff[i];
               tog_v[i]  = act_v[i];
               nxt_oe[i] = (i < `CC_DBL_OFS);
            end
            default: begin
               act_v[i] = 1'b0;
            end
         endcase
      end
      nxt_pin = ((pin_ff ^ tog_v) & ~clr_v) | set_v;
      ev_v    = {tbb.ovf, tba.ovf, cap_v | act_v};
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         pin_ff <= '0;
         oe_ff  <= '0;
      end else begin
         pin_ff <= nxt_pin;
         oe_ff  <= nxt_oe;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         spent_ff <= '0;
         done_ff  <= '0;
      end else begin
         spent_ff <= (spent_ff & ~cfg_we) | (act_v & single_v);
         done_ff  <= (done_ff & ~ovf_v & ~cfg_we) | (act_v & once_v);
      end
   end

   assign CC_PIN_O    = pin_ff;
   assign CC_PIN_OE_O = oe_ff;

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   assign w1c = (apb_wr && hit(PADDR_I, `CC_IRQ_STAT_OFS)) ? PWDATA_I[`CC_IRQ_MSB:0] : '0;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         stat_ff <= '0;
         mask_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~w1c) | ev_v;
         if (apb_wr && hit(PADDR_I, `CC_IRQ_MASK_OFS)) begin
            mask_ff <= PWDATA_I[`CC_IRQ_MSB:0];
         end
      end
   end

   assign IRQ_O = |(stat_ff & mask_ff);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   capture_store_a : assert property (
      cap_v[3] |=> ch_val_ff[3] == $past(cap_cnt[3]))
      else $error("capture did not store the time base count");

   capture_irq_a : assert property (
      (|cap_v) |=> (stat_ff[15:0] & $past(cap_v)) == $past(cap_v))
      else $error("capture did not set its status bit");

   toggle_pin_a : assert property (
      (|tog_v) |=> ((pin_ff ^ $past(pin_ff)) & $past(tog_v)) == $past(tog_v))
      else $error("compare match did not toggle the pin");

   set_on_match_a : assert property (
      (|set_v) |=> (pin_ff & $past(set_v)) == $past(set_v))
      else $error("mode 3 match did not drive the pin high");

   once_per_period_a : assert property (
      (|(act_v & once_v)) |=> (done_ff & $past(act_v) & $past(once_v)) == ($past(act_v) & $past(once_v)))
      else $error("once-per-period event did not block further events");

   single_event_a : assert property (
      (|(act_v & single_v)) |=> (spent_ff & $past(act_v) & $past(single_v)) == ($past(act_v) & $past(single_v)))
      else $error("single-event channel was not frozen after acting");

   disabled_quiet_a : assert property (
      ch_cfg_ff[4].mode == CC_DIS |=> $stable(pin_ff[4]) && (stat_ff[4] <= $past(stat_ff[4])))
      else $error("disabled channel changed its pin or request");

   match_irq_a : assert property (
      match_v[0] && (ch_cfg_ff[0].mode == CC_CMP0) && !spent_ff[0] |=> stat_ff[0] ##0 $stable(pin_ff[0]))
      else $error("mode 0 match did not interrupt or moved the pin");

   capture_seen_c  : cover property (|cap_v);
   double_toggle_c : cover property (ch_cfg_ff[0].mode == CC_DBL && match_v[8] && tog_v[0]);
   mode3_clear_c   : cover property (clr_v[2] && pin_ff[2] ##1 !pin_ff[2]);
   single_spent_c  : cover property ($rose(spent_ff[1]));

endmodule

// ---- rtl/cc_map.svh ----
// register map, field positions, reset values and count constants of the capture/compare unit
`ifndef CC_MAP_SVH
`define CC_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CC_CTRL_OFS       12'h000
`define CC_TBA_CTRL_OFS   12'h004
`define CC_TBA_CNT_OFS    12'h008
`define CC_TBA_RLD_OFS    12'h00c
`define CC_TBB_CTRL_OFS   12'h010
`define CC_TBB_CNT_OFS    12'h014
`define CC_TBB_RLD_OFS    12'h018
`define CC_IRQ_STAT_OFS   12'h01c
`define CC_IRQ_MASK_OFS   12'h020
`define CC_CH_CFG_OFS     12'h040
`define CC_CH_VAL_OFS     12'h080

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CC_REGION_LSB     6
`define CC_STAGGER_BIT    0
`define CC_TB_CFG_MSB     3
`define CC_CH_CFG_MSB     6
`define CC_IRQ_MSB        17

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define CC_RST_CNT        16'h0000
`define CC_CNT_MAX        16'hffff
`define CC_CLK_GPT        3'h6
`define CC_CLK_EXT        3'h7
`define CC_STAGGER_SHIFT  4'h3
`define CC_NUM_CH         16
`define CC_DBL_OFS        8

`endif

// ---- rtl/cc_pkg.sv ----
// types shared by the capture/compare unit
package cc_pkg;

   typedef enum logic [2:0] {
      CC_DIS  = 3'h0,
      CC_CAP  = 3'h1,
      CC_CMP0 = 3'h2,
      CC_CMP1 = 3'h3,
      CC_CMP2 = 3'h4,
      CC_CMP3 = 3'h5,
      CC_DBL  = 3'h6
   } cc_mode_t;

   typedef struct packed {
      logic       single;
      logic [1:0] edge_sel;
      logic       tb_sel;
      cc_mode_t   mode;
   } cc_chcfg_t;

   typedef struct packed {
      logic       run;
      logic [2:0] clk_sel;
   } cc_tbcfg_t;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic        step;
      logic        ovf;
   } cc_tbout_t;

   typedef struct packed {
      logic [16:0] rise;
      logic [16:0] fall;
   } cc_edges_t;

endpackage

// ---- rtl/cc_pin_sync.sv ----
// two-stage synchroniser and edge detector for channel pins and the external count pin
module cc_pin_sync
   import cc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // raw pins
   input  wire logic [16:0] pins_i,
   // synchronised edges
   output cc_edges_t        edges_o
);
   logic [16:0] meta_ff;
   logic [16:0] sync_ff;
   logic [16:0] prev_ff;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= pins_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign edges_o = '{rise: sync_ff & ~prev_ff, fall: ~sync_ff & prev_ff};

endmodule

// ---- rtl/cc_timebase.sv ----
// time base: 16-bit up counter with reload, prescaled or event clocked
module cc_timebase
   import cc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // configuration
   input  cc_tbcfg_t        cfg_i,
   input  wire logic        stagger_i,
   // count sources
   input  wire logic        gpt_ovf_i,
   input  wire logic        ext_tick_i,
   // software access
   input  wire logic        cnt_we_i,
   input  wire logic        rld_we_i,
   input  wire logic [15:0] wdata_i,
   // state
   output cc_tbout_t        tb_o
);
   logic [9:0]  pre_ff;
   logic [9:0]  pre_mask;
   logic [3:0]  expo;
   logic        tick;
   logic [15:0] count_ff;
   logic [15:0] reload_ff;
   logic        step_ff;
   logic        ovf_ff;

   // staggered mode slows the base rate
   always_comb begin
      expo     = {1'b0, cfg_i.clk_sel} + (stagger_i ? `CC_STAGGER_SHIFT : 4'h0);
      pre_mask = 10'((11'h1 << expo) - 11'h1);
      case (cfg_i.clk_sel)
         `CC_CLK_GPT: tick = gpt_ovf_i;
         `CC_CLK_EXT: tick = ext_tick_i;
         default:     tick = (pre_ff & pre_mask) == pre_mask;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + 10'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         count_ff <= `CC_RST_CNT;
         step_ff  <= 1'b0;
         ovf_ff   <= 1'b0;
      end else begin
         step_ff <= 1'b0;
         ovf_ff  <= 1'b0;
         if (cnt_we_i) begin
            count_ff <= wdata_i;
         end else if (cfg_i.run && tick) begin
            step_ff <= 1'b1;
            if (count_ff == `CC_CNT_MAX) begin
               count_ff <= reload_ff;
               ovf_ff   <= 1'b1;
            end else begin
               count_ff <= count_ff + 16'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reload_ff <= `CC_RST_CNT;
      end else if (rld_we_i) begin
         reload_ff <= wdata_i;
      end
   end

   assign tb_o = '{count: count_ff, reload: reload_ff, step: step_ff, ovf: ovf_ff};

   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   reload_on_wrap_a : assert property (
      ovf_ff |-> ($past(count_ff) == `CC_CNT_MAX) && (count_ff == $past(reload_ff)))
      else $error("counter did not reload after overflow");

   stagger_gap_a : assert property (
      step_ff && stagger_i && (cfg_i.clk_sel == 3'h0) |=>
      (!step_ff || !stagger_i || (cfg_i.clk_sel != 3'h0))[*7])
      else $error("staggered time base stepped faster than every eight cycles");

endmodule

// ---- verification/cc_pin_model.sv ----
// model of the pins, external count input and gp timer overflow around the unit
module cc_pin_model (
   // clock
   input  wire logic        clk_i,
   // pin drivers of the unit
   input  wire logic [15:0] pin_o_i,
   input  wire logic [15:0] pin_oe_i,
   // levels seen by the unit
   output logic [15:0]      pin_i_o,
   output logic             ext_o,
   output logic             gpt_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] drv_ff;

   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_ff);

   initial begin
      drv_ff = 16'h0000;
      ext_o  = 1'b0;
      gpt_o  = 1'b0;
   end

   task automatic gpt_tick();
      @(posedge clk_i);
      gpt_o <= 1'b1;
      @(posedge clk_i);
      gpt_o <= 1'b0;
   endtask

   task automatic ext_tick();
      @(posedge clk_i);
      ext_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic set_pin(input int n, input logic v);
      @(posedge clk_i);
      drv_ff[n] <= v;
   endtask
endmodule

// ---- verification/cc_capcom_tb.sv ----
// self-checking testbench of the capture/compare unit
`include "cc_map.svh"
module cc_capcom_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq, ext, gpt, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, base;
   logic [15:0] pin_in, pin_out, pin_oe;
   logic [7:0]  cfg [6] = '{8'h02, 8'h03, 8'h05, 8'h19, 8'h00, 8'h04};
   int          errors = 0;
   int          checks = 0;

   cc_capcom u_dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CC_PIN_I(pin_in), .CC_PIN_O(pin_out), .CC_PIN_OE_O(pin_oe), .EXT_COUNT_I(ext), .GPT_OVF_I(gpt),
      .IRQ_O(irq));
   cc_pin_model u_pins (.clk_i(clk), .pin_o_i(pin_out), .pin_oe_i(pin_oe), .pin_i_o(pin_in), .ext_o(ext),
      .gpt_o(gpt));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask

   task automatic print_verdict();
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rdchk("tba_cnt_rst", `CC_TBA_CNT_OFS, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped_err", 32'h1, 32'(er));
      chk("unmapped_data", 32'h0, rd);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `CC_CH_CFG_OFS + 12'(4 * i), 32'(cfg[i]));
         apb(1'b1, `CC_CH_VAL_OFS + 12'(4 * i), 32'h5);
      end
      apb(1'b1, `CC_IRQ_MASK_OFS, 32'h3ffff);
      apb(1'b1, `CC_TBA_RLD_OFS, 32'hfffe);
      apb(1'b1, `CC_TBA_CNT_OFS, 32'h3);
      apb(1'b1, `CC_TBA_CTRL_OFS, 32'he);
      repeat (2) u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      rdchk("stat_match", `CC_IRQ_STAT_OFS, 32'h27);
      chk("pin_match", 32'h6, 32'(pin_out[4:0]));
      chk("oe_match", 32'h6, 32'(pin_oe[4:0]));
      chk("irq_set", 32'h1, 32'(irq));
      apb(1'b1, `CC_IRQ_STAT_OFS, 32'h3ffff);
      rdchk("stat_clear", `CC_IRQ_STAT_OFS, 32'h0);
      chk("irq_clear", 32'h0, 32'(irq));
      apb(1'b1, `CC_TBA_CNT_OFS, 32'h4);
      u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      rdchk("stat_again", `CC_IRQ_STAT_OFS, 32'h3);
      chk("pin_again", 32'h4, 32'(pin_out[4:0]));
      apb(1'b1, `CC_IRQ_STAT_OFS, 32'h3ffff);
      apb(1'b1, `CC_TBA_CNT_OFS, 32'hffff);
      u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      rdchk("stat_ovf", `CC_IRQ_STAT_OFS, 32'h10000);
      chk("pin_ovf", 32'h0, 32'(pin_out[4:0]));
      rdchk("tba_reload", `CC_TBA_CNT_OFS, 32'hfffe);
      apb(1'b1, `CC_IRQ_STAT_OFS, 32'h3ffff);
      apb(1'b1, `CC_TBB_CNT_OFS, 32'h10);
      apb(1'b1, `CC_TBB_CTRL_OFS, 32'hf);
      repeat (3) u_pins.ext_tick();
      rdchk("tbb_ext", `CC_TBB_CNT_OFS, 32'h13);
      u_pins.set_pin(3, 1'b1);
      repeat (8) @(posedge clk);
      rdchk("cap_val", `CC_CH_VAL_OFS + 12'hc, 32'h13);
      rdchk("cap_stat", `CC_IRQ_STAT_OFS, 32'h8);
      apb(1'b1, `CC_IRQ_STAT_OFS, 32'h3ffff);
      u_pins.set_pin(3, 1'b0);
      repeat (8) @(posedge clk);
      rdchk("cap_fall", `CC_IRQ_STAT_OFS, 32'h0);
      // double register on ch0 with partner ch8, single event on ch1
      apb(1'b1, `CC_CH_CFG_OFS, 32'h06);
      apb(1'b1, `CC_CH_VAL_OFS + 12'h20, 32'h6);
      apb(1'b1, `CC_CH_CFG_OFS + 12'h4, 32'h43);
      apb(1'b1, `CC_TBA_CNT_OFS, 32'h4);
      u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      chk("dbl_first", 32'h3, 32'(pin_out[1:0]));
      chk("dbl_oe", 32'h3, 32'(pin_oe[1:0]));
      u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      chk("dbl_partner", 32'h2, 32'(pin_out[1:0]));
      apb(1'b1, `CC_TBA_CNT_OFS, 32'h4);
      u_pins.gpt_tick();
      repeat (4) @(posedge clk);
      chk("single_once", 32'h3, 32'(pin_out[1:0]));
      rdchk("stat_dbl", `CC_IRQ_STAT_OFS, 32'h27);
      // staggered base: snapshots 64 cycles apart see exactly 8 steps
      apb(1'b1, `CC_CTRL_OFS, 32'h1);
      apb(1'b1, `CC_TBB_CTRL_OFS, 32'h8);
      apb(1'b0, `CC_TBB_CNT_OFS, 32'h0);
      base = rd;
      repeat (61) @(posedge clk);
      rdchk("tb_stagger", `CC_TBB_CNT_OFS, base + 32'h8);
      print_verdict();
   end
endmodule
